// file: logic/opctl_top.v
// Operator panel run control: run/stop, stepping, manual entry, sense and protect
// Overview of operation
// - Suppress every drum write until the drum-speed delay reports full speed.
// - At drum ready, light the run-button lamp and switch-matching lamps.
// - Running lamp while phases cycle; halted lamp when stopped in phase 1 or 3.
// - When halted, a run press resumes sequencing from the stopped point.
// - With single-step engaged, halt in phase 3 after each instruction.
// - Single-step plus input-setup press loads read-in order 08 into the order flops.
// - Without single-step, input-setup press clears the lower accumulator.
// - Execute-from-accumulator works only in single-step; fetch next from lower acc.
// - Two-word read-in puts first word in upper acc; last stays in lower acc.
// - With single-step and execute-from-accumulator, input end moves lower acc into command register and halts in phase 3 before executing it.
// - Branch lamp follows branch flag; branch button resets the flag.
// - Sense order 00 sets branch flag if operand track bit matches a switch.
// - Protect switches block writes to tracks 0-15 and 16-31 respectively.
// - Single-step input-setup substitutes read-in order; command register unchanged.
// - Next run press executes the read-in order, then halts in phase 1 with read-in still open.
// - In single-step each run press executes, fetches the next, and halts.
// - Phases cycle search, load, operand search, execute; halts at boundaries, and at read-in end in single-step with execute-from-accumulator.
// - Halt order or single-step blocks operand search until a run start.
// - In single-step, block each time a command word is loaded.
`timescale 1ns/1ps
`include "opctl_consts.vh"

module opctl_top #(
    parameter DEB_CYC = `OPCTL_DEB_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Drum and word-time strobes from the machine
    input wire drum_ready,
    input wire word_end,
    input wire search_hit,
    input wire exec_done,
    input wire halt_order,
    input wire input_end,
    // Momentary panel buttons
    input wire run_button,
    input wire set_input_btn,
    input wire branch_reset_btn,
    // Latching panel switches
    input wire single_step_sw,
    input wire exec_lower_sw,
    input wire [5:0] sense_sw,
    input wire protect_lo_sw,
    input wire protect_hi_sw,
    // Machine data
    input wire [31:0] mem_word,
    input wire [31:0] input_word,
    input wire input_word_valid,
    input wire [6:0] write_track,
    input wire write_req,
    // Sequencer and register outputs
    output reg [1:0] phase_q,
    output reg [31:0] cmd_q,
    output reg [4:0] order_q,
    output reg [31:0] upper_acc_q,
    output reg [31:0] lower_acc_q,
    output reg write_en_q,
    // Lamps
    output reg run_lamp_q,
    output reg running_lamp_q,
    output reg halted_lamp_q,
    output reg branch_lamp_q,
    output reg step_lamp_q,
    output reg exec_lower_lamp_q
);
    reg ready_s1_q, ready_s2_q;
    reg [5:0] ss1_q, ss2_q;
    reg [31:0] sw1_q, sw2_q;
    reg [5:0] sense_sq;
    reg step_q, exl_q, prot_lo_q, prot_hi_q;
    reg blocked_q;
    reg stopped_q;
    reg readin_q;
    reg [1:0] in_words_q;
    reg [12:0] next_addr_q;
    wire run_p, setin_p, brrst_p;
    reg [6:0] wtrk_q;
    reg wreq_q;

    function prot_hit;
        input [6:0] trk;
        input lo;
        input hi;
        begin
            prot_hit = (lo && trk <= `OPCTL_WP0_LAST) ||
                (hi && trk >= `OPCTL_WP1_FIRST && trk <= `OPCTL_WP1_LAST);
        end
    endfunction

    opctl_debounce #(.DEB_CYC(DEB_CYC)) u_run (
        .core_clk(core_clk), .rst_n(rst_n), .btn_raw(run_button), .press_q(run_p));
    opctl_debounce #(.DEB_CYC(DEB_CYC)) u_set (
        .core_clk(core_clk), .rst_n(rst_n), .btn_raw(set_input_btn), .press_q(setin_p));
    opctl_debounce #(.DEB_CYC(DEB_CYC)) u_brr (
        .core_clk(core_clk), .rst_n(rst_n), .btn_raw(branch_reset_btn), .press_q(brrst_p));

    wire drum_ok = ready_s2_q;
    wire at_boundary = word_end && !stopped_q;

    // Drum-ready, sense and switch pins pass two flops; the first stage feeds only the second
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_s1_q <= 1'b0;
            ready_s2_q <= 1'b0;
            ss1_q <= 6'h0;
            ss2_q <= 6'h0;
            sw1_q <= 32'h0;
            sw2_q <= 32'h0;
        end else begin
            ready_s1_q <= drum_ready;
            ready_s2_q <= ready_s1_q;
            ss1_q <= sense_sw;
            ss2_q <= ss1_q;
            sw1_q <= {28'h0, single_step_sw, exec_lower_sw, protect_lo_sw, protect_hi_sw};
            sw2_q <= sw1_q;
        end
    end

    // Switch levels sampled at every word-end strobe so a flip mid-word has no effect
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= 1'b0;
            exl_q <= 1'b0;
            prot_lo_q <= 1'b1;
            prot_hi_q <= 1'b1;
            sense_sq <= 6'h0;
        end else if (word_end && (at_boundary || stopped_q || blocked_q)) begin
            step_q <= sw2_q[3];
            exl_q <= sw2_q[2];
            prot_lo_q <= sw2_q[1];
            prot_hi_q <= sw2_q[0];
            sense_sq <= ss2_q;
        end
    end

    // Write path runs on registered requests so write_en_q is a flop
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wtrk_q <= 7'h0;
            wreq_q <= 1'b0;
            write_en_q <= 1'b0;
        end else begin
            wtrk_q <= write_track;
            wreq_q <= write_req;
            write_en_q <= wreq_q && drum_ok &&
                !prot_hit(wtrk_q, prot_lo_q, prot_hi_q);
        end
    end

    // Phase sequencer with panel control
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= `OPCTL_PH1;
            cmd_q <= `OPCTL_RESET_WORD;
            order_q <= 5'h0;
            upper_acc_q <= `OPCTL_RESET_WORD;
            lower_acc_q <= `OPCTL_RESET_WORD;
            blocked_q <= 1'b0;
            stopped_q <= 1'b1;
            readin_q <= 1'b0;
            in_words_q <= 2'h0;
            next_addr_q <= 13'h0;
            branch_lamp_q <= 1'b0;
        end else if (drum_ok) begin
            // Manual read-in: newest word lands in lower, older shifts to upper
            if (readin_q && input_word_valid) begin
                upper_acc_q <= lower_acc_q;
                lower_acc_q <= input_word;
                if (in_words_q != 2'h3) begin
                    in_words_q <= in_words_q + 2'h1;
                end
            end
            // A step-mode halt is the blocked state, so input setup is taken there too
            if (setin_p && (stopped_q || blocked_q)) begin
                if (step_q) begin
                    order_q <= `OPCTL_ORD_INPUT;
                    next_addr_q <= cmd_q[`OPCTL_NXT_HI:`OPCTL_NXT_LO];
                    readin_q <= 1'b1;
                    in_words_q <= 2'h0;
                    phase_q <= `OPCTL_PH4;
                end else begin
                    lower_acc_q <= `OPCTL_RESET_WORD;
                end
            end else if (run_p && (stopped_q || blocked_q)) begin
                stopped_q <= 1'b0;
                blocked_q <= 1'b0;
            end else if (readin_q && (input_end || (run_p && !stopped_q))) begin
                readin_q <= 1'b0;
                if (step_q && exl_q) begin
                    cmd_q <= lower_acc_q;
                    order_q <= lower_acc_q[`OPCTL_OP_HI:`OPCTL_OP_LO];
                    phase_q <= `OPCTL_PH3;
                    blocked_q <= 1'b1;
                end else begin
                    phase_q <= `OPCTL_PH1;
                end
            end else if (at_boundary && !blocked_q) begin
                case (phase_q)
                    `OPCTL_PH1: begin
                        if (search_hit) begin
                            phase_q <= `OPCTL_PH2;
                        end
                    end
                    `OPCTL_PH2: begin
                        cmd_q <= mem_word;
                        order_q <= mem_word[`OPCTL_OP_HI:`OPCTL_OP_LO];
                        phase_q <= `OPCTL_PH3;
                        blocked_q <= step_q || halt_order;
                    end
                    `OPCTL_PH3: begin
                        if (search_hit) begin
                            phase_q <= `OPCTL_PH4;
                        end
                    end
                    `OPCTL_PH4: begin
                        if (exec_done) begin
                            if (order_q == `OPCTL_ORD_SENSE &&
                                |(cmd_q[`OPCTL_OPTRK_LO+5:`OPCTL_OPTRK_LO] & sense_sq)) begin
                                branch_lamp_q <= 1'b1;
                            end
                            phase_q <= `OPCTL_PH1;
                            if (readin_q && step_q) begin
                                stopped_q <= 1'b1;
                            end
                        end
                    end
                    default: phase_q <= `OPCTL_PH1;
                endcase
            end
            if (brrst_p) begin
                branch_lamp_q <= 1'b0;
            end
        end
    end

    // Lamps
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_lamp_q <= 1'b0;
            running_lamp_q <= 1'b0;
            halted_lamp_q <= 1'b0;
            step_lamp_q <= 1'b0;
            exec_lower_lamp_q <= 1'b0;
        end else begin
            run_lamp_q <= drum_ok;
            step_lamp_q <= drum_ok && step_q;
            exec_lower_lamp_q <= drum_ok && exl_q;
            running_lamp_q <= drum_ok && !stopped_q && !blocked_q;
            halted_lamp_q <= drum_ok && (stopped_q || blocked_q) &&
                (phase_q == `OPCTL_PH1 || phase_q == `OPCTL_PH3);
        end
    end
endmodule

// file: logic/opctl_consts.vh
// Constants for the operator panel run control block
`ifndef OPCTL_CONSTS_VH
`define OPCTL_CONSTS_VH

// Phase codes of the sequencer
`define OPCTL_PH1 2'h0
`define OPCTL_PH2 2'h1
`define OPCTL_PH3 2'h2
`define OPCTL_PH4 2'h3

// Instruction word fields (32-bit word)
`define OPCTL_OP_HI 31
`define OPCTL_OP_LO 27
`define OPCTL_OPTRK_HI 26
`define OPCTL_OPTRK_LO 20
`define OPCTL_NXT_HI 13
`define OPCTL_NXT_LO 1

// Order codes
`define OPCTL_ORD_SENSE 5'h00
`define OPCTL_ORD_INPUT 5'h08

// Write-protect track ranges
`define OPCTL_WP0_LAST 7'h0f
`define OPCTL_WP1_FIRST 7'h10
`define OPCTL_WP1_LAST 7'h1f

// Debounce settle time in microseconds, and in cycles at 100 MHz
`define OPCTL_DEB_US 1000
`define OPCTL_CLK_MHZ 100
`define OPCTL_DEB_CYC (`OPCTL_DEB_US * `OPCTL_CLK_MHZ)

// Drum-speed delay is its own ready input alone; OPCTL_SPIN_MARGIN is not used
`define OPCTL_SPIN_MARGIN 16
`define OPCTL_RESET_WORD 32'h00000000

`endif

// file: logic/opctl_debounce.v
// Button synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
`include "opctl_consts.vh"

module opctl_debounce #(
    parameter DEB_CYC = `OPCTL_DEB_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Raw button and pulse
    input wire btn_raw,
    output reg press_q
);
    reg sync1_q;
    reg sync2_q;
    reg stable_q;
    reg [31:0] cnt_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            stable_q <= 1'b0;
            cnt_q <= 32'h0;
            press_q <= 1'b0;
        end else begin
            sync1_q <= btn_raw;
            sync2_q <= sync1_q;
            press_q <= 1'b0;
            if (sync2_q == stable_q) begin
                cnt_q <= 32'h0;
            end else if (cnt_q >= DEB_CYC - 1) begin
                // Level held long enough: accept it, pulse only on the press edge
                cnt_q <= 32'h0;
                stable_q <= sync2_q;
                press_q <= sync2_q;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule

// file: tb/opctl_top_chk.sv
// Port assertions for the operator panel run control
`timescale 1ns/1ps
module opctl_top_chk (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Watched inputs
    input wire drum_ready,
    input wire write_req,
    input wire [6:0] write_track,
    input wire protect_lo_sw,
    input wire single_step_sw,
    input wire branch_reset_btn,
    // Watched outputs
    input wire [1:0] phase_q,
    input wire write_en_q,
    input wire run_lamp_q,
    input wire running_lamp_q,
    input wire halted_lamp_q,
    input wire branch_lamp_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_write_cause: assert property (write_en_q |-> $past(write_req, 2))
        else $error("drum write without request");
    chk_write_early: assert property ((!$past(drum_ready) && !$past(drum_ready, 2)
        && !$past(drum_ready, 3)) |-> !write_en_q) else $error("write before drum ready");
    chk_protect_low: assert property ((write_en_q && $past(write_track, 2) <= 7'h0f)
        |-> !$past(protect_lo_sw, 2)) else $error("write into protected low tracks");
    chk_ready_lamp: assert property (drum_ready [*8] |-> run_lamp_q)
        else $error("run lamp dark after drum ready");
    chk_lamp_excl: assert property (!(running_lamp_q && halted_lamp_q))
        else $error("running and halted lamps together");
    chk_halt_phase: assert property (halted_lamp_q |-> $past(phase_q) inside {2'h0, 2'h2})
        else $error("halted outside phase 1 or 3");
    chk_exec_exit: assert property (($past(phase_q) == 2'h3 && phase_q != 2'h3)
        |-> phase_q == 2'h0) else $error("execution not followed by search");
    chk_load_exit: assert property (($past(phase_q) == 2'h1 && phase_q != 2'h1)
        |-> phase_q == 2'h2) else $error("load not followed by operand search");
    chk_step_block: assert property ((phase_q == 2'h2 && $past(phase_q) == 2'h1
        && single_step_sw && $past(single_step_sw, 8)) |-> ##1 (phase_q == 2'h2) [*3]
        ##0 halted_lamp_q) else $error("step mode did not block");
    chk_branch_set: assert property ($rose(branch_lamp_q)
        |-> $past(phase_q) == 2'h3)
        else $error("branch flag set outside execution");
    chk_branch_clr: assert property (branch_reset_btn [*8] |-> ##[0:4] !branch_lamp_q)
        else $error("branch flag not reset");
endmodule

bind opctl_top opctl_top_chk chk_u (.core_clk, .rst_n, .drum_ready, .write_req, .write_track,
    .protect_lo_sw, .single_step_sw, .branch_reset_btn, .phase_q, .write_en_q, .run_lamp_q,
    .running_lamp_q, .halted_lamp_q, .branch_lamp_q);

// file: tb/opctl_operator.sv
// Operator model pressing panel buttons, with contact chatter
`timescale 1ns/1ps
module opctl_operator #(
    parameter int HOLD = 10
) (
    // Clock
    input wire core_clk,
    // Press request and button contacts
    input wire [2:0] push,
    output reg [2:0] btn
);
    int cnt = 0;
    reg [2:0] sel = 3'h0;
    initial btn = 3'h0;
    // First closure opens again briefly, as a real contact does
    always @(negedge core_clk) begin
        if (cnt == 0 && push != 3'h0) begin
            sel <= push;
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        btn <= (cnt > 0 && cnt != HOLD - 1) ? sel : 3'h0;
    end
endmodule

// file: tb/opctl_top_test.sv
// Self-checking bench for the operator panel run control
`timescale 1ns/1ps
module opctl_top_test;
    reg core_clk = 0, rst_n = 0, drum_ready = 0, word_end = 0, search_hit = 0, exec_done = 1;
    reg halt_order = 0, input_end = 0, single_step_sw = 0, exec_lower_sw = 0;
    reg protect_lo_sw = 1, protect_hi_sw = 0, input_word_valid = 0, write_req = 0;
    reg [5:0] sense_sw = 6'h05;
    reg [31:0] mem_word = 32'h00400000, input_word = 0, w1, w2, c;
    reg [6:0] write_track = 7'h20;
    reg [2:0] push = 0;
    wire [2:0] btn;
    wire [1:0] phase_q;
    wire [31:0] cmd_q, upper_acc_q, lower_acc_q;
    wire [4:0] order_q;
    wire write_en_q, run_lamp_q, running_lamp_q, halted_lamp_q, branch_lamp_q, step_lamp_q;
    wire exec_lower_lamp_q;
    int bad_count = 0, checks = 0, n, wt = 0;

    opctl_top #(.DEB_CYC(4)) dut_u (.core_clk, .rst_n, .drum_ready, .word_end, .search_hit,
        .exec_done, .halt_order, .input_end, .run_button(btn[0]), .set_input_btn(btn[1]),
        .branch_reset_btn(btn[2]), .single_step_sw, .exec_lower_sw, .sense_sw, .protect_lo_sw,
        .protect_hi_sw, .mem_word, .input_word, .input_word_valid, .write_track, .write_req,
        .phase_q, .cmd_q, .order_q, .upper_acc_q, .lower_acc_q, .write_en_q, .run_lamp_q,
        .running_lamp_q, .halted_lamp_q, .branch_lamp_q, .step_lamp_q, .exec_lower_lamp_q);
    opctl_operator op_u (.core_clk, .push, .btn);

    initial forever #5 core_clk = ~core_clk;
    // Word-time strobe every fourth cycle; the drum finds addresses at random
    always @(negedge core_clk) begin
        wt <= (wt + 1) % 4;
        word_end <= (wt == 3);
        search_hit <= 1'($urandom % 2);
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task press(input [2:0] b);
        push = b;
        repeat (2) @(negedge core_clk);
        push = 0;
        repeat (16) @(negedge core_clk);
    endtask
    task wrap_up;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h00c6));
        repeat (12) @(negedge core_clk);
        rst_n = 1;
        write_req = 1;
        repeat (6) @(negedge core_clk);
        check(write_en_q, 0, "write_en_q early");
        drum_ready = 1;
        repeat (8) @(negedge core_clk);
        check(run_lamp_q, 1, "run_lamp_q");
        // Boundary tracks first, then random ones, under each protect switch
        for (n = 0; n < 12; n++) begin
            protect_lo_sw = n < 6;
            protect_hi_sw = n >= 6;
            write_track = n % 6 == 0 ? 7'h0f : n % 6 == 1 ? 7'h10 : 7'($urandom % 32);
            repeat (8) @(negedge core_clk);
            check(write_en_q, protect_lo_sw ? write_track > 7'h0f : write_track < 7'h10,
                "write_en_q");
        end
        write_req = 0;
        press(3'h1);
        for (n = 0; n < 100 && running_lamp_q !== 1; n++) @(negedge core_clk);
        check(running_lamp_q, 1, "running_lamp_q");
        for (n = 0; n < 400 && branch_lamp_q !== 1; n++) @(negedge core_clk);
        check(branch_lamp_q, 1, "branch_lamp_q set");
        mem_word = {5'h01, 27'($urandom)};
        // Old sense order must be gone from the command register or it sets the flag again
        for (n = 0; n < 400 && cmd_q[31:27] !== 5'h01; n++) @(negedge core_clk);
        repeat (20) @(negedge core_clk);
        press(3'h4);
        check(branch_lamp_q, 0, "branch_lamp_q clear");
        single_step_sw = 1;
        for (n = 0; n < 400 && halted_lamp_q !== 1; n++) @(negedge core_clk);
        check(phase_q, 2'h2, "phase_q halted");
        check(step_lamp_q, 1, "step_lamp_q");
        w1 = {5'h02, 27'($urandom)};
        mem_word = w1;
        press(3'h1);
        for (n = 0; n < 400 && !(halted_lamp_q === 1 && cmd_q === w1); n++) @(negedge core_clk);
        check(cmd_q, w1, "cmd_q step");
        c = cmd_q;
        press(3'h2);
        check(order_q, 5'h08, "order_q");
        check(cmd_q, c, "cmd_q kept");
        exec_lower_sw = 1;
        press(3'h1);
        check(phase_q, 2'h0, "phase_q read-in");
        check(halted_lamp_q, 1, "halted_lamp_q read-in");
        check(exec_lower_lamp_q, 1, "exec_lower_lamp_q");
        w1 = $urandom;
        w2 = {5'h03, 27'($urandom)};
        for (n = 0; n < 2; n++) begin
            input_word = n ? w2 : w1;
            input_word_valid = 1;
            @(negedge core_clk);
            input_word_valid = 0;
            repeat (3) @(negedge core_clk);
        end
        check(upper_acc_q, w1, "upper_acc_q");
        check(lower_acc_q, w2, "lower_acc_q");
        input_end = 1;
        @(negedge core_clk);
        input_end = 0;
        for (n = 0; n < 100 && cmd_q !== w2; n++) @(negedge core_clk);
        check(cmd_q, w2, "cmd_q from lower");
        exec_lower_sw = 0;
        single_step_sw = 0;
        repeat (12) @(negedge core_clk);
        press(3'h2);
        check(lower_acc_q, 0, "lower_acc_q clear");
        wrap_up;
    end
endmodule
